// ===== logic/ppg_pkg.sv
// Package for the parallel port GPIO block: register map and pin carriers
package ppg_pkg;
	localparam int PPG_LINES = 46;
	localparam int PPG_GRP = 16;
	// Printed offsets are not multiples of four: they are indices, byte address is index*4
	localparam logic [15:0] PPG_IDX_EN_LOW = 16'h4400;
	localparam logic [15:0] PPG_IDX_DIR_LOW = 16'h4401;
	localparam logic [15:0] PPG_IDX_VAL_LOW = 16'h4402;
	localparam logic [15:0] PPG_IDX_EN_MID = 16'h4403;
	localparam logic [15:0] PPG_IDX_DIR_MID = 16'h4404;
	localparam logic [15:0] PPG_IDX_VAL_MID = 16'h4405;
	localparam logic [15:0] PPG_IDX_EN_HIGH = 16'h4406;
	localparam logic [15:0] PPG_IDX_DIR_HIGH = 16'h4407;
	localparam logic [15:0] PPG_IDX_VAL_HIGH = 16'h4408;
	localparam logic [15:0] PPG_IDX_BUS_SEL = 16'h4409;
	localparam logic [15:0] PPG_EN_RESET = 16'h0000;
	localparam logic [15:0] PPG_DIR_RESET = 16'h0000;
	localparam logic PPG_MUX_RESET = 1'b0;
	localparam int PPG_MUX_BIT = 0;
	localparam logic PPG_MUX_GPIO = 1'b0;
	// Line positions of each pin group
	localparam int PPG_ADDR_BASE = 0;
	localparam int PPG_DATA_BASE = 4;
	localparam int PPG_CTRL_BASE = 20;
	localparam int PPG_HD_BASE = 36;
	localparam int PPG_HC0_LINE = 44;
	localparam int PPG_HC1_LINE = 45;

	typedef struct packed {
		logic [3:0] addr_hi;   // address pins 21..18
		logic [15:0] data_hi;  // data pins 31..16
		logic [15:0] ctrl;     // control pins 15..0
		logic [7:0] hd;        // host port data pins 7..0
		logic hc1;
		logic hc0;
	} ppg_pins_t;

	typedef struct packed {
		logic [31:0] haddr;
		logic [1:0] htrans;
		logic hwrite;
		logic [2:0] hsize;
		logic hsel;
	} ppg_ahb_req_t;
endpackage

// ===== logic/ppg_top.sv
// Parallel port GPIO block with AHB-Lite register slave
//
// Functional notes
// [R1] Pins act as GPIO only while the bus-select mux field is 0.
// [R2] Enable 0 disables a line's output driver, enable 1 lets it drive.
// [R3] Direction picks whether the value bit is driven out or sampled in.
// [R4] Enable and direction both 1 make the line drive its value bit.
// [R5] Enable and direction both 0 make reads return the sampled pin level.
// [R6] Software keeps enable and direction equal; other pairs are unsupported.
// [R7] Full memory interface mode overrides the enable bits.
// [R8] Address pins 21..18 are lines 3..0 and data pins 31..16 lines 19..4.
// [R9] Control pins 0..15 are lines 20..35 in order.
// [R10] Host data pins 7..0 are lines 43..36, host controls lines 44 and 45.
// [R11] Enable, direction and value each have three 16-bit registers.
// [R12] Low enable register at index 4400h, lines 15..0, resets to zero.
// [R13] Low direction register at index 4401h, resets to input.
// [R14] Value registers hold sampled input or written output levels.
// [R15] Low value register at index 4402h, reset follows pin levels.
// [R16] Mid enable register at index 4403h, lines 31..16, resets to zero.
// [R17] An enable of 0 keeps the line's driver off.
`timescale 1ns/1ps
module ppg_top import ppg_pkg::*; (
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Repurposed pins
	input wire ppg_pins_t pin_in,
	output ppg_pins_t pin_out,
	output ppg_pins_t pin_oe,
	// Mode, to the memory and host port logic
	output logic gpio_mode
);
	// ------------------------------------------------------------
	// Pin to line mapping
	// ------------------------------------------------------------
	logic [PPG_LINES-1:0] line_in;
	assign line_in[PPG_DATA_BASE-1:PPG_ADDR_BASE] = pin_in.addr_hi; // see [R8]
	assign line_in[PPG_CTRL_BASE-1:PPG_DATA_BASE] = pin_in.data_hi; // see [R8]
	assign line_in[PPG_HD_BASE-1:PPG_CTRL_BASE] = pin_in.ctrl; // see [R9]
	assign line_in[PPG_HC0_LINE-1:PPG_HD_BASE] = pin_in.hd; // see [R10]
	assign line_in[PPG_HC0_LINE] = pin_in.hc0; // see [R10]
	assign line_in[PPG_HC1_LINE] = pin_in.hc1; // see [R10]

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	logic [3*PPG_GRP-1:0] en_q, en_d;
	logic [3*PPG_GRP-1:0] dir_q, dir_d;
	logic [3*PPG_GRP-1:0] val_q, val_d;
	logic mux_q, mux_d;
	logic seed_q;
	logic [3*PPG_GRP-1:0] line_in_w;
	logic [3*PPG_GRP-1:0] line_mask_w;
	logic gpio_on;

	assign line_in_w = {2'b00, line_in};
	// Lines 46 and 47 do not exist, so their control bits read back 0
	assign line_mask_w = {{(3*PPG_GRP-PPG_LINES){1'b0}}, {PPG_LINES{1'b1}}};
	assign gpio_on = (mux_q == PPG_MUX_GPIO); // see [R1]

	// ------------------------------------------------------------
	// AHB-Lite address phase capture
	// ------------------------------------------------------------
	logic wr_pend_q;
	logic [15:0] idx_q;
	logic addr_ok_w;
	logic take_w;
	logic [15:0] idx_w;

	assign take_w = hsel && hready && htrans[1];
	assign idx_w = haddr[17:2];
	// Only aligned whole-word transfers reach a register
	assign addr_ok_w = (haddr[1:0] == 2'b00) && (haddr[31:18] == 14'h0000) && (hsize == 3'h2);

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			wr_pend_q <= 1'b0;
			idx_q <= 16'h0000;
		end else begin
			wr_pend_q <= take_w && hwrite && addr_ok_w;
			idx_q <= addr_ok_w ? idx_w : 16'hffff;
		end
	end

	// ------------------------------------------------------------
	// Register decode
	// ------------------------------------------------------------
	logic [2:0] sel_en, sel_dir, sel_val;
	logic sel_mux;
	assign sel_en = {idx_q == PPG_IDX_EN_HIGH, idx_q == PPG_IDX_EN_MID, idx_q == PPG_IDX_EN_LOW}; // see [R12] see [R16]
	assign sel_dir = {idx_q == PPG_IDX_DIR_HIGH, idx_q == PPG_IDX_DIR_MID, idx_q == PPG_IDX_DIR_LOW}; // see [R13]
	assign sel_val = {idx_q == PPG_IDX_VAL_HIGH, idx_q == PPG_IDX_VAL_MID, idx_q == PPG_IDX_VAL_LOW}; // see [R15]
	assign sel_mux = (idx_q == PPG_IDX_BUS_SEL);

	// Group write and input sampling, three 16-bit groups
	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : grp // see [R11]
			logic [PPG_GRP-1:0] v_in;
			logic [PPG_GRP-1:0] dir_g;
			logic [PPG_GRP-1:0] hold_g;
			logic [PPG_GRP-1:0] wr_g;
			logic en_wr;
			logic dir_wr;
			logic val_wr;
			assign v_in = line_in_w[g*PPG_GRP +: PPG_GRP];
			assign dir_g = dir_q[g*PPG_GRP +: PPG_GRP];
			assign hold_g = val_q[g*PPG_GRP +: PPG_GRP];
			assign en_wr = wr_pend_q && sel_en[g];
			assign dir_wr = wr_pend_q && sel_dir[g];
			assign val_wr = wr_pend_q && sel_val[g];
			assign en_d[g*PPG_GRP +: PPG_GRP] = en_wr ? hwdata[PPG_GRP-1:0] : en_q[g*PPG_GRP +: PPG_GRP];
			assign dir_d[g*PPG_GRP +: PPG_GRP] = dir_wr ? hwdata[PPG_GRP-1:0] : dir_q[g*PPG_GRP +: PPG_GRP];
			// Input lines track the pin; output lines keep what software wrote
			assign wr_g = val_wr ? hwdata[PPG_GRP-1:0] : hold_g; // see [R14]
			assign val_d[g*PPG_GRP +: PPG_GRP] = !seed_q ? v_in : ((dir_g & wr_g) | (~dir_g & v_in)); // see [R3] see [R15]
		end
	endgenerate

	assign mux_d = (wr_pend_q && sel_mux) ? hwdata[PPG_MUX_BIT] : mux_q;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			en_q <= {3{PPG_EN_RESET}}; // see [R12] see [R16]
			dir_q <= {3{PPG_DIR_RESET}}; // see [R13]
			mux_q <= PPG_MUX_RESET;
		end else begin
			en_q <= en_d & line_mask_w;
			dir_q <= dir_d & line_mask_w;
			mux_q <= mux_d;
		end
	end

	// Value reset depends on pins, so it is seeded by a clocked load after release
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			seed_q <= 1'b0;
			val_q <= '0;
		end else begin
			seed_q <= 1'b1;
			val_q <= val_d;
		end
	end

	// ------------------------------------------------------------
	// Pin drivers
	// ------------------------------------------------------------
	logic [PPG_LINES-1:0] drv_oe_w, drv_out_w;
	// Enable alone gates the driver; the mux overrides it in memory mode
	assign drv_oe_w = gpio_on ? en_q[PPG_LINES-1:0] : '0; // see [R2] see [R7] see [R17]
	assign drv_out_w = val_q[PPG_LINES-1:0]; // see [R4]

	ppg_pins_t oe_w, out_w;
	assign oe_w = {drv_oe_w[PPG_DATA_BASE-1:0], drv_oe_w[PPG_CTRL_BASE-1:PPG_DATA_BASE],
		drv_oe_w[PPG_HD_BASE-1:PPG_CTRL_BASE], drv_oe_w[PPG_HC0_LINE-1:PPG_HD_BASE],
		drv_oe_w[PPG_HC1_LINE], drv_oe_w[PPG_HC0_LINE]}; // see [R8] see [R9] see [R10]
	assign out_w = {drv_out_w[PPG_DATA_BASE-1:0], drv_out_w[PPG_CTRL_BASE-1:PPG_DATA_BASE],
		drv_out_w[PPG_HD_BASE-1:PPG_CTRL_BASE], drv_out_w[PPG_HC0_LINE-1:PPG_HD_BASE],
		drv_out_w[PPG_HC1_LINE], drv_out_w[PPG_HC0_LINE]};

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			pin_oe <= '0;
			pin_out <= '0;
			gpio_mode <= 1'b1;
		end else begin
			pin_oe <= oe_w;
			pin_out <= out_w;
			gpio_mode <= gpio_on; // see [R1]
		end
	end

	// ------------------------------------------------------------
	// Read data
	// ------------------------------------------------------------
	logic [15:0] rd_w;
	always_comb begin
		rd_w = 16'h0000;
		for (int k = 0; k < 3; k++) begin
			if (sel_en[k])
				rd_w = en_q[k*PPG_GRP +: PPG_GRP];
			if (sel_dir[k])
				rd_w = dir_q[k*PPG_GRP +: PPG_GRP];
			if (sel_val[k])
				rd_w = val_q[k*PPG_GRP +: PPG_GRP]; // see [R5]
		end
		if (sel_mux)
			rd_w = {15'h0000, mux_q};
	end

	// ------------------------------------------------------------
	// Read handshake
	// ------------------------------------------------------------
	// One wait state lets read data come from a flop; writes never wait
	typedef enum logic [1:0] {
		BUS_IDLE = 2'b00,
		BUS_RD_WAIT = 2'b01,
		BUS_RD_DATA = 2'b11
	} ppg_bus_state_t;
	ppg_bus_state_t bus_q, bus_d;
	logic rd_take_w;
	logic rd_load_w;
	logic ready_d_w;
	assign rd_take_w = take_w && !hwrite;
	assign rd_load_w = (bus_q == BUS_RD_WAIT);
	assign ready_d_w = (bus_d != BUS_RD_WAIT);

	always_comb begin
		bus_d = bus_q;
		case (bus_q)
			BUS_IDLE: begin
				if (rd_take_w)
					bus_d = BUS_RD_WAIT;
			end
			BUS_RD_WAIT: begin
				bus_d = BUS_RD_DATA;
			end
			BUS_RD_DATA: begin
				bus_d = rd_take_w ? BUS_RD_WAIT : BUS_IDLE;
			end
			default: begin
				bus_d = BUS_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			bus_q <= BUS_IDLE;
			hrdata <= 32'h00000000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			bus_q <= bus_d;
			hreadyout <= ready_d_w;
			hresp <= 1'b0;
			if (rd_load_w)
				hrdata <= {16'h0000, rd_w};
		end
	end
endmodule

// ===== verification/ppg_monitor.sv
// Checker on the ports of the parallel port GPIO block
`timescale 1ns/1ps
module ppg_monitor import ppg_pkg::*; (
	// Bus
	input wire logic clock,
	input wire logic rst,
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	// Pins and mode
	input wire ppg_pins_t pin_oe,
	input wire logic gpio_mode
);
	logic rd_w, wr_w, wd_q;
	assign rd_w = hsel && hready && htrans[1] && !hwrite;
	assign wr_w = hsel && hready && htrans[1] && hwrite;
	// Write data phase marker, so pin changes can be traced to a write
	always_ff @(posedge clock or posedge rst) begin
		if (rst)
			wd_q <= 1'b0;
		else
			wd_q <= wr_w;
	end
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	chk_read_wait: assert property (rd_w |=> !hreadyout ##1 hreadyout) else $error("read wait");
	chk_write_fast: assert property (wr_w |=> hreadyout) else $error("write wait");
	chk_resp_okay: assert property (hresp == 1'b0) else $error("resp not okay");
	chk_upper_zero: assert property (hreadyout |-> hrdata[31:16] == 16'h0) else $error("upper data");
	chk_mode_reset: assert property ($past(rst) |-> gpio_mode) else $error("mode reset");
	chk_oe_reset: assert property ($past(rst) |-> pin_oe == '0) else $error("oe reset");
	chk_mem_mode: assert property (!gpio_mode && !$past(gpio_mode) |-> pin_oe == '0) else $error("mux");
	chk_rdata_hold: assert property ($changed(hrdata) |-> !$past(hreadyout)) else $error("rdata moved");
	chk_oe_cause: assert property ($changed(pin_oe) |-> $past(wd_q) || $past(wd_q, 2) || $past(wd_q, 3))
		else $error("oe without write");
endmodule
bind ppg_top ppg_monitor ppg_monitor_inst (.clock, .rst, .hsel, .htrans, .hwrite, .hready, .hrdata, .hreadyout,
	.hresp, .pin_oe, .gpio_mode);

// ===== verification/ppg_board.sv
// Board logic wired to the reused pins
`timescale 1ns/1ps
module ppg_board import ppg_pkg::*; (
	// From the block
	input wire ppg_pins_t pin_out,
	input wire ppg_pins_t pin_oe,
	// Board side levels
	input wire ppg_pins_t ext,
	output ppg_pins_t pin_in
);
	// Released lines follow the board
	assign pin_in = (pin_out & pin_oe) | (ext & ~pin_oe);
endmodule

// ===== verification/test_parallel_port_gpio.sv
// Testbench for the parallel port GPIO block
`timescale 1ns/1ps
module test_parallel_port_gpio;
	import ppg_pkg::*;
	typedef struct {logic [31:0] a, d, e;} ppg_row_t;
	logic clock = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r;
	logic hreadyout, hresp, gpio_mode;
	logic [45:0] lv;
	ppg_pins_t pin_in, pin_out, pin_oe;
	ppg_pins_t ext = 46'h2a5ac3c35a96;
	int n_errors = 0, checks = 0, cyc = 0;
	// Last row aliases the low enable index above the mapped range: it must be refused
	ppg_row_t rows[8] = '{'{32'h11000, 32'hffff, 32'hffff}, '{32'h11004, 32'hffff, 32'hffff},
		'{32'h1100c, 32'hffff, 32'hffff}, '{32'h11010, 32'hffff, 32'hffff}, '{32'h11018, 32'hffff, 32'h3fff},
		'{32'h1101c, 32'hffff, 32'h3fff}, '{32'h11028, 32'hffff, 32'h0}, '{32'h51000, 32'h0, 32'h0}};
	always #12.5 clock = ~clock;
	ppg_top ppg_top_inst (.clock, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
		.hrdata, .hreadyout, .hresp, .pin_in, .pin_out, .pin_oe, .gpio_mode);
	ppg_board ppg_board_inst (.pin_out, .pin_oe, .ext, .pin_in);
	function automatic ppg_pins_t l2p(input logic [45:0] l);
		return {l[3:0], l[19:4], l[35:20], l[43:36], l[45], l[44]};
	endfunction
	function automatic logic [45:0] p2l(input ppg_pins_t p);
		return {p.hc1, p.hc0, p.hd, p.ctrl, p.data_hi, p.addr_hi};
	endfunction
	task automatic chk(input logic [47:0] seen, exp, input string nm);
		checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// Master never assumes a latency: it waits on hready each phase
	task automatic xfer(input logic w, input logic [31:0] a, d);
		@(posedge clock);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		@(posedge clock);
		while (hreadyout !== 1'b1) @(posedge clock);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge clock);
		while (hreadyout !== 1'b1) @(posedge clock);
		r = hrdata;
	endtask
	task automatic rd(input logic [31:0] a, e, input string nm);
		xfer(1'b0, a, 32'h0);
		chk(r, e, nm);
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	always @(posedge clock) begin
		cyc++;
		if (cyc == 3000) begin
			n_errors++;
			give_verdict();
		end
	end
	initial begin
		repeat (12) @(posedge clock);
		rst <= 1'b0;
		lv = p2l(ext);
		rd(32'h11000, 32'h0, "en_low");
		rd(32'h11004, 32'h0, "dir_low");
		rd(32'h11008, {16'h0, lv[15:0]}, "val_low");
		rd(32'h1100c, 32'h0, "en_mid");
		$display("test reset done");
		foreach (rows[i]) begin
			xfer(1'b1, rows[i].a, rows[i].d);
			rd(rows[i].a, rows[i].e, "table");
		end
		$display("test table done");
		xfer(1'b1, 32'h11008, 32'h1234);
		xfer(1'b1, 32'h11014, 32'h5678);
		xfer(1'b1, 32'h11020, 32'h2abc);
		repeat (2) @(posedge clock);
		chk(pin_oe, l2p({46{1'b1}}), "oe");
		chk(pin_out, l2p({14'h2abc, 16'h5678, 16'h1234}), "out");
		rd(32'h11014, 32'h5678, "val_mid");
		$display("test output done");
		xfer(1'b1, 32'h11024, 32'h1);
		repeat (2) @(posedge clock);
		chk(pin_oe, 46'h0, "oe_mem");
		chk(gpio_mode, 1'b0, "mode");
		rd(32'h11024, 32'h1, "mux_rd");
		xfer(1'b1, 32'h11024, 32'h0);
		repeat (2) @(posedge clock);
		chk(pin_oe, l2p({46{1'b1}}), "oe_gpio");
		$display("test mux done");
		for (int i = 0; i < 6; i++) xfer(1'b1, rows[i].a, 32'h0);
		ext <= 46'h15a53c3ca569;
		repeat (4) @(posedge clock);
		lv = p2l(ext);
		chk(pin_oe, 46'h0, "oe_in");
		rd(32'h11008, {16'h0, lv[15:0]}, "in_low");
		rd(32'h11014, {16'h0, lv[31:16]}, "in_mid");
		rd(32'h11020, {18'h0, lv[45:32]}, "in_high");
		$display("test input done");
		xfer(1'b1, 32'h11000, 32'hffff);
		xfer(1'b1, 32'h11004, 32'hffff);
		xfer(1'b1, 32'h11024, 32'h1);
		@(posedge clock);
		rst <= 1'b1;
		repeat (2) @(posedge clock);
		chk(pin_oe, 46'h0, "oe_rst");
		chk(gpio_mode, 1'b1, "mode_rst");
		chk(hresp, 1'b0, "resp_rst");
		rst <= 1'b0;
		lv = p2l(ext);
		rd(32'h11000, 32'h0, "en_rst");
		rd(32'h11004, 32'h0, "dir_rst");
		rd(32'h11008, {16'h0, lv[15:0]}, "val_rst");
		rd(32'h11024, 32'h0, "mux_rst");
		$display("test mid reset done");
		give_verdict();
	end
endmodule
